// ### verilog/cfh_pkg.sv
//==========================================================
// Notes on behaviour
// R01: Request/clear mode: attached equipment holding RTS high permits sending toward it.
// R02: Request/clear mode: stop transmitting toward the equipment whenever RTS is low.
// R03: Request/clear mode: CTS high while we can accept data, low otherwise.
// R04: Ready-pair mode: DSR high while we can accept data, low otherwise.
// R05: Ready-pair mode: DTR high permits sending; DTR low halts our transmission.
// R06: Flow usage overrides assert/pass line usage; other signal options are unspecified.
// R07: Line-sense family: four variants from clear and sense polarity choices.
// R08: High-active clear variants: CTS asserted when ready, deasserted when not.
// R09: Low-active clear variants: CTS asserted when not ready, deasserted when ready.
// R10: High-active sense variants: input high permits sending, low stops it.
// R11: Low-active sense variants: input high stops sending, low permits it.
// R12: Synchronous channel without flow control keeps CTS permanently asserted.
// R13: Counted-frame channel: CTS low when buffer space is short for the frame.
// R14: Counted-frame channel: CTS held low until the concentrated link is up.
// R15: Synchronous or counted-frame without flow control keeps DSR asserted.
// R16: Synchronous or counted-frame without flow control keeps carrier detect asserted.
// R17: Synchronous or counted-frame without flow control keeps ring indicator deasserted.
// R18: Mode and polarity are static configuration, sampled synchronously.
package cfh_pkg;

	//==========================================================
	// Register map
	localparam logic [3:0] CFH_OFS_CTRL = 4'h0;
	localparam logic [3:0] CFH_OFS_STATUS = 4'h4;
	localparam logic [3:0] CFH_OFS_FRAME = 4'h8;

	//==========================================================
	// Channel configuration
	typedef enum logic [1:0] {
		CFH_CH_ASYNC = 2'h0,
		CFH_CH_SYNC = 2'h1,
		CFH_CH_COUNTED = 2'h2,
		CFH_CH_UNUSED = 2'h3
	} cfh_chan_e;

	typedef enum logic [1:0] {
		CFH_FL_NONE = 2'h0,
		CFH_FL_REQ_CLEAR = 2'h1,
		CFH_FL_READY_PAIR = 2'h2,
		CFH_FL_LINE_SENSE = 2'h3
	} cfh_flow_e;

	typedef enum logic [1:0] {
		CFH_SIG_ASSERT = 2'h0,
		CFH_SIG_PASS = 2'h1,
		CFH_SIG_DIAL = 2'h2,
		CFH_SIG_OTHER = 2'h3
	} cfh_sig_e;

	// Variant code: bit 1 low-active clear, bit 0 low-active sense
	localparam logic [1:0] clear_high_sense_high_variant = 2'h0;
	localparam logic [1:0] clear_high_sense_low_variant = 2'h1;
	localparam logic [1:0] clear_low_sense_high_variant = 2'h2;
	localparam logic [1:0] clear_low_sense_low_variant = 2'h3;
	localparam int CFH_VAR_CLEAR_LOW_BIT = 1;
	localparam int CFH_VAR_SENSE_LOW_BIT = 0;

	// Control word layout, byte lane 0, chan in the low bits
	typedef struct packed {
		cfh_sig_e sig_opt;
		logic [1:0] variant;
		cfh_flow_e flow;
		cfh_chan_e chan;
	} cfh_cfg_s;

	localparam logic [7:0] CFH_CFG_RESET = 8'h00;
	localparam int CFH_CFG_W = 8;

	//==========================================================
	// Line groups
	typedef struct packed {
		logic cts;
		logic dsr;
		logic car;
		logic ri;
	} cfh_lines_s;

	typedef struct packed {
		logic rts;
		logic dtr;
		logic line_sense;
	} cfh_sense_s;

	localparam int CFH_LEN_W = 16;

	//==========================================================
	// Status word bit positions
	localparam int CFH_ST_LINES_LSB = 0;
	localparam int CFH_ST_SENSE_LSB = 4;
	localparam int CFH_ST_PERMIT = 7;
	localparam int CFH_ST_LINK = 8;
	localparam int CFH_ST_CONFLICT = 9;
	localparam int CFH_ST_SHORT = 10;

	//==========================================================
	// Bus slave states
	typedef enum logic [1:0] {
		CFH_BUS_IDLE = 2'h0,
		CFH_BUS_RESP = 2'h1
	} cfh_bus_e;

endpackage

// ### verilog/cfh_flow_handshake.sv
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
module cfh_flow_handshake (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Incoming handshake pins
	input wire logic rts_in,
	input wire logic dtr_in,
	input wire logic reverse_line_sense_in,
	// Outgoing handshake pins
	output logic cts_out,
	output logic dsr_out,
	output logic car_out,
	output logic ri_out,
	// Channel data path
	input wire logic rx_ready,
	input wire logic link_up,
	input wire logic hdr_valid,
	input wire logic [15:0] hdr_len,
	input wire logic [15:0] buf_free,
	output logic tx_permit
);

	//==========================================================
	// State
	typedef struct packed {
		cfh_pkg::cfh_bus_e bus;
		logic waitreq;
		logic [31:0] rdata;
		cfh_pkg::cfh_cfg_s cfg;
		cfh_pkg::cfh_sense_s sync1;
		cfh_pkg::cfh_sense_s sync2;
		cfh_pkg::cfh_lines_s lines;
		logic permit;
		logic [15:0] frame_len;
		logic frame_short;
	} cfh_state_s;

	cfh_state_s s_q;
	cfh_state_s s_d;

	logic clear_low;
	logic sense_low;
	logic sense_ok;
	logic flow_on;
	logic conflict;
	logic [15:0] len_now;
	logic short_now;
	logic [31:0] status_word;
	logic [31:0] frame_word;

	//==========================================================
	// Next state
	always_comb begin
		s_d = s_q;

		// Pins cross in; only the second stage is looked at
		s_d.sync1 = {rts_in, dtr_in, reverse_line_sense_in};
		s_d.sync2 = s_q.sync1;

		// R07: polarity variant decode
		clear_low = s_q.cfg.variant[cfh_pkg::CFH_VAR_CLEAR_LOW_BIT];
		sense_low = s_q.cfg.variant[cfh_pkg::CFH_VAR_SENSE_LOW_BIT];
		// R10: R11: sense level that permits sending
		sense_ok = s_q.sync2.line_sense ^ sense_low;

		flow_on = (s_q.cfg.flow != cfh_pkg::CFH_FL_NONE);
		// R06: only assert/pass combine cleanly with a flow mode
		conflict = flow_on && (s_q.cfg.chan == cfh_pkg::CFH_CH_ASYNC) &&
			(s_q.cfg.sig_opt != cfh_pkg::CFH_SIG_ASSERT) &&
			(s_q.cfg.sig_opt != cfh_pkg::CFH_SIG_PASS);

		// R13: size of the frame in hand, new header wins
		len_now = hdr_valid ? hdr_len : s_q.frame_len;
		short_now = (buf_free < len_now);
		if (hdr_valid) begin
			s_d.frame_len = hdr_len;
		end
		s_d.frame_short = short_now;

		// Idle line levels, as for the assert option
		s_d.lines.cts = 1'b1;
		s_d.lines.dsr = 1'b1;
		s_d.lines.car = 1'b1;
		s_d.lines.ri = 1'b0;
		s_d.permit = 1'b1;

		case (s_q.cfg.chan)
			cfh_pkg::CFH_CH_ASYNC: begin
				// R06: flow usage overrides the signal option usage
				case (s_q.cfg.flow)
					cfh_pkg::CFH_FL_REQ_CLEAR: begin
						// R03: clear follows our receive readiness
						s_d.lines.cts = rx_ready;
						// R01: R02: request line gates sending
						s_d.permit = s_q.sync2.rts;
					end
					cfh_pkg::CFH_FL_READY_PAIR: begin
						// R04: ready output follows receive readiness
						s_d.lines.dsr = rx_ready;
						// R05: terminal ready gates sending
						s_d.permit = s_q.sync2.dtr;
					end
					cfh_pkg::CFH_FL_LINE_SENSE: begin
						// R08: R09: clear polarity per variant
						s_d.lines.cts = rx_ready ^ clear_low;
						// R10: R11: sense polarity per variant
						s_d.permit = sense_ok;
					end
					default: begin
						s_d.permit = 1'b1;
					end
				endcase
			end
			cfh_pkg::CFH_CH_SYNC: begin
				// R12: full duplex, clear always on
				s_d.lines.cts = 1'b1;
				// R15: R16: R17: fixed line levels
				s_d.lines.dsr = 1'b1;
				s_d.lines.car = 1'b1;
				s_d.lines.ri = 1'b0;
			end
			cfh_pkg::CFH_CH_COUNTED: begin
				// R13: R14: clear only with link up and room for the frame
				s_d.lines.cts = link_up && !short_now;
				// R15: R16: R17: fixed line levels
				s_d.lines.dsr = 1'b1;
				s_d.lines.car = 1'b1;
				s_d.lines.ri = 1'b0;
			end
			default: begin
				// Unused channel keeps the far side quiet
				s_d.lines = '0;
				s_d.permit = 1'b0;
			end
		endcase

		// Register read words
		status_word = '0;
		status_word[cfh_pkg::CFH_ST_LINES_LSB +: 4] = s_q.lines;
		status_word[cfh_pkg::CFH_ST_SENSE_LSB +: 3] = s_q.sync2;
		status_word[cfh_pkg::CFH_ST_PERMIT] = s_q.permit;
		status_word[cfh_pkg::CFH_ST_LINK] = link_up;
		status_word[cfh_pkg::CFH_ST_CONFLICT] = conflict;
		status_word[cfh_pkg::CFH_ST_SHORT] = s_q.frame_short;
		frame_word = {buf_free, s_q.frame_len};

		// Avalon slave: one wait cycle, answer on the second
		case (s_q.bus)
			cfh_pkg::CFH_BUS_IDLE: begin
				s_d.waitreq = 1'b1;
				if (avs_read || avs_write) begin
					s_d.bus = cfh_pkg::CFH_BUS_RESP;
					s_d.waitreq = 1'b0;
					if (avs_read) begin
						case (avs_address)
							cfh_pkg::CFH_OFS_CTRL: s_d.rdata = {24'h000000, s_q.cfg};
							cfh_pkg::CFH_OFS_STATUS: s_d.rdata = status_word;
							cfh_pkg::CFH_OFS_FRAME: s_d.rdata = frame_word;
							default: s_d.rdata = 32'h00000000;
						endcase
					end
				end
			end
			cfh_pkg::CFH_BUS_RESP: begin
				s_d.bus = cfh_pkg::CFH_BUS_IDLE;
				s_d.waitreq = 1'b1;
				// R18: configuration taken only at the bus edge
				if (avs_write && avs_byteenable[0] && (avs_address == cfh_pkg::CFH_OFS_CTRL)) begin
					s_d.cfg = cfh_pkg::cfh_cfg_s'(avs_writedata[cfh_pkg::CFH_CFG_W-1:0]);
				end
			end
			default: begin
				s_d.bus = cfh_pkg::CFH_BUS_IDLE;
				s_d.waitreq = 1'b1;
			end
		endcase
	end

	//==========================================================
	// Registers
	always_ff @(posedge clock) begin
		if (rst) begin
			s_q <= '0;
			s_q.waitreq <= 1'b1;
			s_q.cfg <= cfh_pkg::CFH_CFG_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = s_q.waitreq;
	assign cts_out = s_q.lines.cts;
	assign dsr_out = s_q.lines.dsr;
	assign car_out = s_q.lines.car;
	assign ri_out = s_q.lines.ri;
	assign tx_permit = s_q.permit;

	//==========================================================
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	logic is_async;
	logic is_rc;
	logic is_rp;
	logic is_ls;
	logic is_fixed;
	assign is_async = (s_q.cfg.chan == cfh_pkg::CFH_CH_ASYNC);
	assign is_rc = is_async && (s_q.cfg.flow == cfh_pkg::CFH_FL_REQ_CLEAR);
	assign is_rp = is_async && (s_q.cfg.flow == cfh_pkg::CFH_FL_READY_PAIR);
	assign is_ls = is_async && (s_q.cfg.flow == cfh_pkg::CFH_FL_LINE_SENSE);
	assign is_fixed = (s_q.cfg.chan == cfh_pkg::CFH_CH_SYNC) || (s_q.cfg.chan == cfh_pkg::CFH_CH_COUNTED);

	a_rc_permit_go: assert property (is_rc && s_q.sync2.rts |=> tx_permit) // R01
		else $error("request high did not permit sending");
	a_rc_permit_stop: assert property (is_rc && !s_q.sync2.rts |=> !tx_permit) // R02
		else $error("request low did not stop sending");
	a_rc_clear_level: assert property (is_rc |=> cts_out == $past(rx_ready)) // R03
		else $error("clear does not follow receive readiness");
	a_rp_ready_level: assert property (is_rp |=> dsr_out == $past(rx_ready)) // R04
		else $error("ready output does not follow receive readiness");
	a_rp_halt_tx: assert property (is_rp |=> tx_permit == $past(s_q.sync2.dtr)) // R05
		else $error("terminal ready does not gate sending");
	a_ls_clear_pol: assert property (is_ls |=> cts_out == ($past(rx_ready) ^ $past(clear_low))) // R08
		else $error("clear polarity wrong for variant");
	a_ls_sense_pol: assert property (is_ls |=> tx_permit == ($past(s_q.sync2.line_sense) ^ $past(sense_low))) // R10
		else $error("sense polarity wrong for variant");
	a_pin_to_permit: assert property (is_rc && $stable(s_q.cfg) ##0 $rose(s_q.sync1.rts) ##1 is_rc
		|=> $rose(tx_permit)) // R01
		else $error("request edge not seen two cycles later");
	a_sync_clear_on: assert property (s_q.cfg.chan == cfh_pkg::CFH_CH_SYNC |=> cts_out) // R12
		else $error("synchronous channel dropped clear");
	a_cf_room_cts: assert property (s_q.cfg.chan == cfh_pkg::CFH_CH_COUNTED && link_up
		|=> cts_out == !$past(short_now)) // R13
		else $error("clear does not track frame room");
	a_cf_link_wait: assert property (s_q.cfg.chan == cfh_pkg::CFH_CH_COUNTED && !link_up |=> !cts_out) // R14
		else $error("clear raised before link up");
	a_fixed_lines: assert property (is_fixed |=> dsr_out && car_out && !ri_out) // R15
		else $error("fixed line levels wrong");
	a_bus_answer: assert property ((avs_read || avs_write) && s_q.bus == cfh_pkg::CFH_BUS_IDLE
		|=> !avs_waitrequest ##1 avs_waitrequest) // R18
		else $error("bus answer not one cycle long");

	c_rc_stop: cover property (is_rc ##1 !tx_permit);
	c_ls_low_low: cover property (is_ls && s_q.cfg.variant == cfh_pkg::clear_low_sense_low_variant ##1 cts_out);
	c_cf_short: cover property (s_q.cfg.chan == cfh_pkg::CFH_CH_COUNTED && link_up ##1 !cts_out);
	c_cfg_write: cover property (avs_write && !avs_waitrequest);

endmodule

// ### verification/cfh_term_model.sv
`timescale 1ns/1ns
//==========================================================
// Attached terminal model
module cfh_term_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Bench control
	input wire logic can_accept,
	input wire logic sense_low,
	// Lines toward the device
	output logic rts,
	output logic dtr,
	output logic line_sense
);
	// readiness on lines
	// Lines move just after an edge, unrelated to the device's sync flops
	always_ff @(posedge clock) begin
		if (rst) begin
			rts <= 1'b0;
			dtr <= 1'b0;
			line_sense <= sense_low;
		end else begin
			rts <= can_accept;
			dtr <= can_accept;
			line_sense <= can_accept ^ sense_low;
		end
	end
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic clock, rst, avs_read, avs_write, rx_ready, link_up, hdr_valid, can_accept, sense_low;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rd, r;
	logic avs_waitrequest, rts_in, dtr_in, sense_in, cts_out, dsr_out, car_out, ri_out, tx_permit;
	logic [15:0] hdr_len, buf_free, len;
	logic [7:0] cfgs [13];
	logic [4:0] ex;
	int n_errors, checks, seed;

	//==========================================================
	// Clock, device and terminal
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	cfh_flow_handshake i_dut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rts_in(rts_in), .dtr_in(dtr_in),
		.reverse_line_sense_in(sense_in), .cts_out(cts_out), .dsr_out(dsr_out), .car_out(car_out),
		.ri_out(ri_out), .rx_ready(rx_ready), .link_up(link_up), .hdr_valid(hdr_valid), .hdr_len(hdr_len),
		.buf_free(buf_free), .tx_permit(tx_permit));

	cfh_term_model i_term (.clock(clock), .rst(rst), .can_accept(can_accept), .sense_low(sense_low),
		.rts(rts_in), .dtr(dtr_in), .line_sense(sense_in));

	//==========================================================
	// Tasks
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, want, seen);
		end
	endtask

	// Request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] q);
		@(posedge clock);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		avs_byteenable <= be;
		// Only the watchdog ends a wait
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic final_report();
		$display("n_errors=%0d checks=%0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Expected {cts, dsr, car, ri, permit}
	function automatic logic [4:0] exp_out(logic [7:0] c, logic rx, logic lk, logic acc, logic [15:0] f,
		logic [15:0] l);
		logic cts, p;
		cts = 1'b1;
		p = 1'b1;
		if (c[1:0] == 2'h3) return 5'h00;
		if (c[3:2] == 2'h1) cts = rx;
		if (c[3:2] == 2'h3) cts = rx ^ c[5];
		if (c[3:2] != 2'h0) p = acc;
		if (c[1:0] == 2'h2) cts = lk && (f >= l);
		return {cts, (c[3:2] == 2'h2) ? rx : 1'b1, 1'b1, 1'b0, p};
	endfunction

	//==========================================================
	// Watchdog
	initial begin
		#(8 * 20000);
		n_errors++;
		final_report();
	end

	//==========================================================
	// Main sequence
	initial begin
		seed = 32'h16c73567;
		n_errors = 0;
		checks = 0;
		{rst, avs_read, avs_write, rx_ready, link_up, hdr_valid, can_accept, sense_low} = 8'h81;
		{avs_address, avs_byteenable, avs_writedata, hdr_len, buf_free} = 72'h0;
		cfgs = '{8'h04, 8'h44, 8'h08, 8'h48, 8'h0c, 8'h1c, 8'h2c, 8'h3c, 8'h01, 8'h02, 8'h00, 8'h84, 8'h03};
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		bus(1'b0, cfh_pkg::CFH_OFS_CTRL, 32'h0, 4'hf, rd);
		check("ctrl_reset", rd, {24'h0, cfh_pkg::CFH_CFG_RESET});
		bus(1'b0, 4'hc, 32'h0, 4'hf, rd);
		check("unmapped", rd, 32'h0);
		foreach (cfgs[k]) begin
			bus(1'b1, cfh_pkg::CFH_OFS_CTRL, {24'h0, cfgs[k]}, 4'hf, rd);
			// Lane 0 disabled, so this write must be dropped
			bus(1'b1, cfh_pkg::CFH_OFS_CTRL, 32'h3f, 4'he, rd);
			// Unmapped writes are dropped as well
			bus(1'b1, 4'hc, 32'h3f, 4'hf, rd);
			bus(1'b0, cfh_pkg::CFH_OFS_CTRL, 32'h0, 4'hf, rd);
			check("ctrl", rd, {24'h0, cfgs[k]});
			for (int i = 0; i < 6; i++) begin
				r = $random(seed);
				len = {8'h0, r[7:0]};
				@(posedge clock);
				rx_ready <= r[17];
				link_up <= (i < 2) | r[18];
				can_accept <= r[19];
				sense_low <= cfgs[k][4];
				hdr_valid <= 1'b1;
				hdr_len <= len;
				buf_free <= (i == 0) ? len : (i == 1) ? len - 16'h1 : {7'h0, r[28:20]};
				@(posedge clock);
				hdr_valid <= 1'b0;
				repeat (4) @(posedge clock);
				@(negedge clock);
				ex = exp_out(cfgs[k], rx_ready, link_up, can_accept, buf_free, len);
				check("cts", 32'(cts_out), 32'(ex[4]));
				check("dsr_car_ri", 32'({dsr_out, car_out, ri_out}), 32'(ex[3:1]));
				check("tx_permit", 32'(tx_permit), 32'(ex[0]));
				bus(1'b0, cfh_pkg::CFH_OFS_STATUS, 32'h0, 4'hf, rd);
				check("status_lines", 32'(rd[3:0]), 32'(ex[4:1]));
				check("status_flags", 32'({rd[9], rd[7]}), 32'({(cfgs[k][1:0] == 2'h0) && (cfgs[k][3:2] != 2'h0) && cfgs[k][7], ex[0]}));
				bus(1'b0, cfh_pkg::CFH_OFS_FRAME, 32'h0, 4'hf, rd);
				check("frame_len", 32'(rd[15:0]), 32'(len));
			end
		end
		final_report();
	end
endmodule
